/* File: inc/host_port_switch_config_regs.svh */
`ifndef HOST_PORT_SWITCH_CONFIG_REGS_SVH
`define HOST_PORT_SWITCH_CONFIG_REGS_SVH

// AXI address width and register byte offsets
`define AXI_AW        12
`define OFF_CFG       12'h000
`define OFF_RAW       12'h004
`define OFF_WDG       12'h008

// Switch positions, switch n sits at index n-1
`define SW_BAUD_LSB   0
`define SW_BAUD_MSB   2
`define SW_ADDR_MSB   4
`define SW_DATA8      3
`define SW_STOP2      4
`define SW_PAR        5
`define SW_EVEN       6
`define SW_FLOW       7
`define SW_MODE       8
`define SW_ROLE       9
`define SW_ZERO_LSB   5
`define SW_ZERO_MSB   6

// Config register fields
`define CB_BUS        0
`define CB_DATA8      1
`define CB_STOP2      2
`define CB_PAR        3
`define CB_EVEN       4
`define CB_FLOW       5
`define CB_CRLF       6
`define CB_TALK       7
`define CB_AUTO       8
`define CB_AFLT       9
`define CB_WDEN       10
`define CB_VALID      11
`define CB_BAUD_LSB   12
`define CB_BAUD_MSB   14
`define CB_ADDR_LSB   16
`define CB_ADDR_MSB   20

// Raw register and watchdog register fields
`define RB_JMP        10
`define RB_SW_MSB     9
`define WB_KICK       0
`define WB_CLR        1
`define WB_FIRED      0

`define RESP_OKAY     2'h0
`define RESP_DECERR   2'h3
`define RST_WORD      32'h0000_0000

// Rates in baud, watchdog time in ms
`define CLK_HZ        125000000
`define BAUD_0        300
`define BAUD_1        600
`define BAUD_2        1200
`define BAUD_3        2000
`define BAUD_4        2400
`define BAUD_5        4800
`define BAUD_6        9600
`define BAUD_7        19200
`define WDOG_TIME_MS  1000
`define MS_PER_S      1000

`endif

/* File: inc/host_port_switch_config_pkg.sv */
`include "host_port_switch_config_regs.svh"

package host_port_switch_config_pkg;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_TAKE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_e;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_TAKE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_e;

  typedef struct packed {
    logic        sampled;
    logic [9:0]  sw;
    logic        jmp;
    logic        busMode;
    logic        dataBits8;
    logic        twoStop;
    logic        parityOn;
    logic        parityEven;
    logic        xonXoff;
    logic        crlf;
    logic        talkerOnly;
    logic        autonomous;
    logic        addrFault;
    logic [2:0]  baudCode;
    logic [4:0]  busAddr;
    logic [31:0] wdCnt;
    logic        wdFired;
    logic        wdPulse;
    wr_state_e   wst;
    rd_state_e   rst;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } state_s;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } tick_s;

endpackage

/* File: src/baud_tick_gen.sv */
`timescale 1ns/100ps
`default_nettype none
`include "host_port_switch_config_regs.svh"

module baud_tick_gen #(
  parameter int CLK_HZ = `CLK_HZ
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       en,
  input  wire logic [2:0] code,
  output logic            tick
);

  host_port_switch_config_pkg::tick_s st_ff;
  host_port_switch_config_pkg::tick_s nxt_st;
  logic [31:0]                        divTab [8];

  function automatic int rateOf(input int idx);
    case (idx)
      0: rateOf = `BAUD_0;
      1: rateOf = `BAUD_1;
      2: rateOf = `BAUD_2;
      3: rateOf = `BAUD_3;
      4: rateOf = `BAUD_4;
      5: rateOf = `BAUD_5;
      6: rateOf = `BAUD_6;
      default: rateOf = `BAUD_7;
    endcase
  endfunction

  for (genvar i = 0; i < 8; i++) begin : g_div
    assign divTab[i] = 32'(CLK_HZ / rateOf(i));
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (!en) begin
      nxt_st.cnt = 32'h0000_0000;
    end else if (st_ff.cnt >= divTab[code] - 32'h0000_0001) begin
      nxt_st.cnt  = 32'h0000_0000;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_tick_spacing: assert property (tick |=> !tick)
    else $error("baud tick repeated on consecutive cycles");

endmodule // baud_tick_gen

`default_nettype wire

/* File: src/host_port_switch_config.sv */
// Contract
// - Baud rate comes from switches 3,2,1 (3 msb), codes 0..7 give 300..19200 baud.
// - In bus mode the device address is switches 1-5; switches 6 and 7 should be zero.
// - In serial mode switch 4 high means 8 data bits, low means 7.
// - In serial mode switch 5 high means two stop bits, low means one.
// - In serial mode switch 6 high adds and checks parity, low omits it.
// - With parity on, switch 7 high selects even parity, low selects odd.
// - In serial mode switch 8 high honours XON/XOFF, low ignores it.
// - In bus mode switch 8 low appends CR/LF, high omits it.
// - Switch 9 high selects the IEEE 488 bus, low the serial link.
// - In bus mode switch 10 high means talker only, low listener and talker.
// - In serial mode switch 10 high means autonomous, low conversational.
// - The watchdog runs only with its jumper fitted and never fires otherwise.
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "host_port_switch_config_regs.svh"

module host_port_switch_config #(
  parameter int CLK_HZ      = `CLK_HZ,
  parameter int WDOG_CYCLES = `WDOG_TIME_MS * (`CLK_HZ / `MS_PER_S)
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [9:0]        switches,
  input  wire logic              wdogJumper,
  input  wire logic [`AXI_AW-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [`AXI_AW-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   cfgValid,
  output logic                   busMode,
  output logic [2:0]             baudCode,
  output logic                   baudTick,
  output logic                   dataBits8,
  output logic                   twoStopBits,
  output logic                   parityOn,
  output logic                   parityEven,
  output logic                   xonXoffOn,
  output logic                   crlfOn,
  output logic                   talkerOnly,
  output logic                   autonomous,
  output logic [4:0]             busAddr,
  output logic                   addrFault,
  output logic                   watchdogFire
);

  localparam logic [31:0] WD_LAST = 32'(WDOG_CYCLES - 1);

  host_port_switch_config_pkg::state_s st_ff;
  host_port_switch_config_pkg::state_s nxt_st;
  logic                                wrKick;
  logic                                wrClr;
  logic [31:0]                         cfgWord;
  logic [31:0]                         rawWord;
  logic [31:0]                         wdgWord;

  always_comb begin
    cfgWord = `RST_WORD;
    cfgWord[`CB_BUS]   = st_ff.busMode;
    cfgWord[`CB_DATA8] = st_ff.dataBits8;
    cfgWord[`CB_STOP2] = st_ff.twoStop;
    cfgWord[`CB_PAR]   = st_ff.parityOn;
    cfgWord[`CB_EVEN]  = st_ff.parityEven;
    cfgWord[`CB_FLOW]  = st_ff.xonXoff;
    cfgWord[`CB_CRLF]  = st_ff.crlf;
    cfgWord[`CB_TALK]  = st_ff.talkerOnly;
    cfgWord[`CB_AUTO]  = st_ff.autonomous;
    cfgWord[`CB_AFLT]  = st_ff.addrFault;
    cfgWord[`CB_WDEN]  = st_ff.jmp;
    cfgWord[`CB_VALID] = st_ff.sampled;
    cfgWord[`CB_BAUD_MSB:`CB_BAUD_LSB] = st_ff.baudCode;
    cfgWord[`CB_ADDR_MSB:`CB_ADDR_LSB] = st_ff.busAddr;
    rawWord = `RST_WORD;
    rawWord[`RB_SW_MSB:0] = st_ff.sw;
    rawWord[`RB_JMP] = st_ff.jmp;
    wdgWord = `RST_WORD;
    wdgWord[`WB_FIRED] = st_ff.wdFired;
  end

  // Watchdog control only acts on a taken write with its low byte enabled
  assign wrKick = (st_ff.wst == host_port_switch_config_pkg::WR_TAKE) &&
                  (awaddr == `OFF_WDG) && wstrb[0] && wdata[`WB_KICK];
  assign wrClr  = (st_ff.wst == host_port_switch_config_pkg::WR_TAKE) &&
                  (awaddr == `OFF_WDG) && wstrb[0] && wdata[`WB_CLR];

  always_comb begin
    nxt_st = st_ff;
    nxt_st.wdPulse = 1'b0;

    // capture once at the first edge after reset release
    if (!st_ff.sampled) begin
      nxt_st.sampled = 1'b1;
      nxt_st.sw      = switches;
      nxt_st.jmp     = wdogJumper;
      nxt_st.busMode = switches[`SW_MODE];
      // baud code, switch 3 most significant
      nxt_st.baudCode = switches[`SW_BAUD_MSB:`SW_BAUD_LSB];
      nxt_st.busAddr   = switches[`SW_ADDR_MSB:0];
      nxt_st.addrFault = switches[`SW_MODE] &&
                         (switches[`SW_ZERO_MSB:`SW_ZERO_LSB] != 2'h0);
      nxt_st.dataBits8 = !switches[`SW_MODE] && switches[`SW_DATA8];
      nxt_st.twoStop = !switches[`SW_MODE] && switches[`SW_STOP2];
      nxt_st.parityOn = !switches[`SW_MODE] && switches[`SW_PAR];
      // parity sense, meaningful only with parity on
      nxt_st.parityEven = !switches[`SW_MODE] && switches[`SW_PAR] &&
                          switches[`SW_EVEN];
      nxt_st.xonXoff = !switches[`SW_MODE] && switches[`SW_FLOW];
      // terminator, active low on switch 8
      nxt_st.crlf = switches[`SW_MODE] && !switches[`SW_FLOW];
      nxt_st.talkerOnly = switches[`SW_MODE] && switches[`SW_ROLE];
      nxt_st.autonomous = !switches[`SW_MODE] && switches[`SW_ROLE];
    end

    // watchdog counts only with the jumper fitted
    if (st_ff.sampled && st_ff.jmp) begin
      if (wrKick) begin
        nxt_st.wdCnt = 32'h0000_0000;
      end else if (st_ff.wdCnt >= WD_LAST) begin
        nxt_st.wdCnt   = 32'h0000_0000;
        nxt_st.wdPulse = 1'b1;
      end else begin
        nxt_st.wdCnt = st_ff.wdCnt + 32'h0000_0001;
      end
    end
    // Expiry in the same cycle as a clear keeps the flag set
    nxt_st.wdFired = (st_ff.wdFired && !wrClr) || nxt_st.wdPulse;

    case (st_ff.wst)
      host_port_switch_config_pkg::WR_IDLE: begin
        if (awvalid && wvalid) begin
          nxt_st.awready = 1'b1;
          nxt_st.wready  = 1'b1;
          nxt_st.wst     = host_port_switch_config_pkg::WR_TAKE;
        end
      end
      host_port_switch_config_pkg::WR_TAKE: begin
        nxt_st.awready = 1'b0;
        nxt_st.wready  = 1'b0;
        nxt_st.bvalid  = 1'b1;
        nxt_st.bresp   = (awaddr == `OFF_CFG || awaddr == `OFF_RAW ||
                          awaddr == `OFF_WDG) ? `RESP_OKAY : `RESP_DECERR;
        nxt_st.wst     = host_port_switch_config_pkg::WR_RESP;
      end
      host_port_switch_config_pkg::WR_RESP: begin
        if (bready) begin
          nxt_st.bvalid = 1'b0;
          nxt_st.wst    = host_port_switch_config_pkg::WR_IDLE;
        end
      end
      default: begin
        nxt_st.awready = 1'b0;
        nxt_st.wready  = 1'b0;
        nxt_st.bvalid  = 1'b0;
        nxt_st.wst     = host_port_switch_config_pkg::WR_IDLE;
      end
    endcase

    case (st_ff.rst)
      host_port_switch_config_pkg::RD_IDLE: begin
        if (arvalid) begin
          nxt_st.arready = 1'b1;
          nxt_st.rst     = host_port_switch_config_pkg::RD_TAKE;
        end
      end
      host_port_switch_config_pkg::RD_TAKE: begin
        nxt_st.arready = 1'b0;
        nxt_st.rvalid  = 1'b1;
        nxt_st.rresp   = `RESP_OKAY;
        case (araddr)
          `OFF_CFG: nxt_st.rdata = cfgWord;
          `OFF_RAW: nxt_st.rdata = rawWord;
          `OFF_WDG: nxt_st.rdata = wdgWord;
          default: begin
            nxt_st.rdata = `RST_WORD;
            nxt_st.rresp = `RESP_DECERR;
          end
        endcase
        nxt_st.rst = host_port_switch_config_pkg::RD_DATA;
      end
      host_port_switch_config_pkg::RD_DATA: begin
        if (rready) begin
          nxt_st.rvalid = 1'b0;
          nxt_st.rst    = host_port_switch_config_pkg::RD_IDLE;
        end
      end
      default: begin
        nxt_st.arready = 1'b0;
        nxt_st.rvalid  = 1'b0;
        nxt_st.rst     = host_port_switch_config_pkg::RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // rate divider runs only in serial mode
  baud_tick_gen #(
    .CLK_HZ (CLK_HZ)
  ) u_baud (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .en      (st_ff.sampled && !st_ff.busMode),
    .code    (st_ff.baudCode),
    .tick    (baudTick)
  );

  assign awready      = st_ff.awready;
  assign wready       = st_ff.wready;
  assign bvalid       = st_ff.bvalid;
  assign bresp        = st_ff.bresp;
  assign arready      = st_ff.arready;
  assign rvalid       = st_ff.rvalid;
  assign rresp        = st_ff.rresp;
  assign rdata        = st_ff.rdata;
  assign cfgValid     = st_ff.sampled;
  assign busMode      = st_ff.busMode;
  assign baudCode     = st_ff.baudCode;
  assign dataBits8    = st_ff.dataBits8;
  assign twoStopBits  = st_ff.twoStop;
  assign parityOn     = st_ff.parityOn;
  assign parityEven   = st_ff.parityEven;
  assign xonXoffOn    = st_ff.xonXoff;
  assign crlfOn       = st_ff.crlf;
  assign talkerOnly   = st_ff.talkerOnly;
  assign autonomous   = st_ff.autonomous;
  assign busAddr      = st_ff.busAddr;
  assign addrFault    = st_ff.addrFault;
  assign watchdogFire = st_ff.wdPulse;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_cap;
    $rose(cfgValid);
  endsequence

  sequence s_wr_start;
    st_ff.wst == host_port_switch_config_pkg::WR_IDLE && awvalid && wvalid;
  endsequence

  sequence s_wr_done;
    awready && wready ##1 bvalid && !awready;
  endsequence

  sequence s_rd_start;
    st_ff.rst == host_port_switch_config_pkg::RD_IDLE && arvalid;
  endsequence

  sequence s_rd_done;
    arready ##1 rvalid && !arready;
  endsequence

  a_baud_code_map: assert property (s_cap |->
      baudCode == $past(switches[`SW_BAUD_MSB:`SW_BAUD_LSB]))
    else $error("baud code differs from switches 3..1");
  a_bus_addr_form: assert property (s_cap ##0 busMode |->
      busAddr == $past(switches[`SW_ADDR_MSB:0]) &&
      addrFault == ($past(switches[`SW_ZERO_MSB:`SW_ZERO_LSB]) != 2'h0))
    else $error("bus address or zero check wrong");
  a_data_bits_sel: assert property (cfgValid |->
      dataBits8 == (!st_ff.sw[`SW_MODE] && st_ff.sw[`SW_DATA8]))
    else $error("data bit count wrong");
  a_stop_bits_sel: assert property (cfgValid && !busMode |->
      twoStopBits == st_ff.sw[`SW_STOP2])
    else $error("stop bit count wrong");
  a_parity_enable: assert property (s_cap |->
      parityOn == (!$past(switches[`SW_MODE]) && $past(switches[`SW_PAR])))
    else $error("parity enable wrong");
  a_parity_sense: assert property (parityEven |-> parityOn && st_ff.sw[`SW_EVEN])
    else $error("even parity without parity or switch");
  a_flow_ctl_sel: assert property (cfgValid |->
      xonXoffOn == (!busMode && st_ff.sw[`SW_FLOW]))
    else $error("flow control setting wrong");
  a_crlf_term_sel: assert property (cfgValid |->
      crlfOn == (busMode && !st_ff.sw[`SW_FLOW]))
    else $error("terminator setting wrong");
  a_port_mode_sel: assert property (s_cap |-> busMode == $past(switches[`SW_MODE]))
    else $error("port mode differs from switch 9");
  a_talker_role: assert property (cfgValid |->
      talkerOnly == (busMode && st_ff.sw[`SW_ROLE]))
    else $error("talker role wrong");
  a_auto_role: assert property (cfgValid |->
      autonomous == (!busMode && st_ff.sw[`SW_ROLE]))
    else $error("autonomous role wrong");
  a_wdog_quiet: assert property (!st_ff.jmp |-> !watchdogFire && !st_ff.wdFired)
    else $error("watchdog fired with jumper removed");
  a_wdog_expiry: assert property (watchdogFire |->
      $past(st_ff.wdCnt) == WD_LAST && st_ff.wdFired)
    else $error("watchdog fired at wrong count");
  a_cfg_hold: assert property (cfgValid && $past(cfgValid) |->
      $stable(st_ff.sw) && $stable(busMode) && $stable(busAddr))
    else $error("configuration changed after capture");
  a_axi_write: assert property (s_wr_start |=> s_wr_done)
    else $error("write response not two cycles after request");
  a_axi_read: assert property (s_rd_start |=> s_rd_done)
    else $error("read data not two cycles after request");
  a_read_hold: assert property (rvalid && !rready |=>
      rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data changed before it was taken");
  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response changed before it was taken");

  a_wdog_kick: assert property (wrKick && st_ff.jmp |=>
      st_ff.wdCnt == 32'h0000_0000 && !watchdogFire)
    else $error("kick did not restart the watchdog");
  a_wdog_clear: assert property (wrClr |=> st_ff.wdFired == watchdogFire)
    else $error("fired flag survived a clear");
  a_baud_quiet: assert property (busMode |-> !baudTick)
    else $error("baud tick in bus mode");
  a_addr_fault_bus: assert property (addrFault |-> busMode)
    else $error("address fault outside bus mode");
  a_cfg_idle: assert property (!cfgValid |-> !busMode && baudCode == 3'h0 &&
      busAddr == 5'h00 && !watchdogFire)
    else $error("configuration outputs active before capture");

endmodule // host_port_switch_config

`default_nettype wire

/* File: bench/host_link_model.sv */
`timescale 1ns/100ps
`default_nettype none

module host_link_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        baudTick,
  output logic [15:0]      tickPeriod,
  output logic [15:0]      tickCount
);
  logic [15:0] gap_ff;
  logic [15:0] period_ff;
  logic [15:0] count_ff;

  // Host receiver times the bit clock it would sample against
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff    <= 16'h0000;
      period_ff <= 16'h0000;
      count_ff  <= 16'h0000;
    end else if (baudTick) begin
      gap_ff    <= 16'h0000;
      period_ff <= gap_ff + 16'h0001;
      count_ff  <= count_ff + 16'h0001;
    end else begin
      gap_ff    <= gap_ff + 16'h0001;
    end
  end

  assign tickPeriod = period_ff;
  assign tickCount  = count_ff;
endmodule // host_link_model

`default_nettype wire

/* File: bench/host_port_switch_config_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "host_port_switch_config_regs.svh"

module host_port_switch_config_tb;
  logic sys_clk, rst_n, wdogJumper, awvalid, wvalid, bready, arvalid, rready;
  logic [9:0] switches;
  logic [`AXI_AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, portWord;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic cfgValid, busMode, baudTick, dataBits8, twoStopBits, parityOn, parityEven;
  logic xonXoffOn, crlfOn, talkerOnly, autonomous, addrFault, watchdogFire;
  logic [2:0] baudCode;
  logic [4:0] busAddr;
  logic [15:0] tickPeriod, tickCount;
  int miscompares, checks, cycles, fires;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [9:0] pat [6] = '{10'h2FD, 10'h042, 10'h027, 10'h313, 10'h1AA, 10'h140};
  int divs [8] = '{640, 320, 160, 96, 80, 40, 20, 10};

  host_port_switch_config #(.CLK_HZ(192000), .WDOG_CYCLES(20)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .switches(switches), .wdogJumper(wdogJumper),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .cfgValid(cfgValid), .busMode(busMode),
    .baudCode(baudCode), .baudTick(baudTick), .dataBits8(dataBits8),
    .twoStopBits(twoStopBits), .parityOn(parityOn), .parityEven(parityEven),
    .xonXoffOn(xonXoffOn), .crlfOn(crlfOn), .talkerOnly(talkerOnly),
    .autonomous(autonomous), .busAddr(busAddr), .addrFault(addrFault),
    .watchdogFire(watchdogFire));

  host_link_model host (.sys_clk(sys_clk), .rst_n(rst_n), .baudTick(baudTick),
    .tickPeriod(tickPeriod), .tickCount(tickCount));

  assign portWord = {11'h000, busAddr, 1'h0, baudCode, cfgValid, 1'h0, addrFault, autonomous,
    talkerOnly, crlfOn, xonXoffOn, parityEven, parityOn, twoStopBits, dataBits8, busMode};

  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (watchdogFire === 1'h1) begin
      fires++;
    end
    if (cycles == 40000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [31:0] expCfg(input logic [9:0] s, input logic j);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[0] = s[8];
    w[1] = !s[8] && s[3];
    w[2] = !s[8] && s[4];
    w[3] = !s[8] && s[5];
    w[4] = !s[8] && s[5] && s[6];
    w[5] = !s[8] && s[7];
    w[6] = s[8] && !s[7];
    w[7] = s[8] && s[9];
    w[8] = !s[8] && s[9];
    w[9] = s[8] && (s[5] || s[6]);
    w[10] = j;
    w[11] = 1'h1;
    w[14:12] = s[2:0];
    w[20:16] = s[4:0];
    return w;
  endfunction

  task automatic applyCfg(input logic [9:0] s, input logic j);
    switches <= s;
    wdogJumper <= j;
    rst_n <= 1'h0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do @(posedge sys_clk); while (!(awready === 1'h1 && wready === 1'h1));
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    while (bvalid !== 1'h1) @(posedge sys_clk);
    r = bresp;
    bready <= 1'h0;
    @(posedge sys_clk);
  endtask

  task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge sys_clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    while (rvalid !== 1'h1) @(posedge sys_clk);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge sys_clk);
  endtask

  initial begin
    rst_n = 1'h0; switches = 10'h000; wdogJumper = 1'h0; awaddr = 12'h000; araddr = 12'h000;
    awvalid = 1'h0; wvalid = 1'h0; wdata = 32'h0; wstrb = 4'hF; bready = 1'h0;
    arvalid = 1'h0; rready = 1'h0;
    miscompares = 0; checks = 0; cycles = 0; fires = 0;
    for (int i = 0; i < 6; i++) begin
      applyCfg(pat[i], i[0]);
      check(portWord, expCfg(pat[i], i[0]) & 32'hFFFF_FBFF, "config ports");
      axiRead(`OFF_CFG, rd, rsp);
      check(rd, expCfg(pat[i], i[0]), "config register");
      axiWrite(`OFF_CFG, 32'hFFFF_FFFF, rsp);
      check({30'h0, rsp}, {30'h0, `RESP_OKAY}, "read-only write resp");
      axiRead(`OFF_RAW, rd, rsp);
      check(rd, {21'h0, i[0], pat[i]}, "raw register");
      switches <= ~pat[i];
      wdogJumper <= ~i[0];
      repeat (3) @(posedge sys_clk);
      check(portWord, expCfg(pat[i], i[0]) & 32'hFFFF_FBFF, "held config");
    end
    axiRead(12'h00C, rd, rsp);
    check(rd, 32'h0, "unmapped read data");
    check({30'h0, rsp}, {30'h0, `RESP_DECERR}, "unmapped read");
    axiWrite(12'h00C, 32'h1, rsp);
    check({30'h0, rsp}, {30'h0, `RESP_DECERR}, "unmapped write");
    for (int c = 0; c < 8; c++) begin
      applyCfg({7'h00, c[2:0]}, 1'h0);
      for (int n = 0; n < 3000 && tickCount < 16'h0003; n++) @(posedge sys_clk);
      check({16'h0, tickPeriod}, divs[c], "baud period");
    end
    applyCfg(10'h100, 1'h0);
    repeat (700) @(posedge sys_clk);
    check({16'h0, tickCount}, 32'h0, "no baud tick in bus mode");
    applyCfg(10'h000, 1'h1);
    fires = 0;
    for (int k = 0; k < 12; k++) axiWrite(`OFF_WDG, 32'h1, rsp);
    check(fires, 0, "kicked watchdog fired");
    repeat (60) @(posedge sys_clk);
    check(fires != 0, 1, "watchdog silent");
    axiRead(`OFF_WDG, rd, rsp);
    check(rd & 32'h1, 32'h1, "fired flag");
    axiWrite(`OFF_WDG, 32'h3, rsp);
    axiRead(`OFF_WDG, rd, rsp);
    check(rd & 32'h1, 32'h0, "cleared flag");
    applyCfg(10'h000, 1'h0);
    fires = 0;
    repeat (100) @(posedge sys_clk);
    check(fires, 0, "watchdog fired without jumper");
    axiRead(`OFF_WDG, rd, rsp);
    check(rd & 32'h1, 32'h0, "fired flag without jumper");
    give_verdict();
  end
endmodule // host_port_switch_config_tb

`default_nettype wire
